//--- core/cal_pkg.sv
/*
 Shared constants for the compare and latch operator block: register
 map, field positions, reset values, relation codes and timing.
 Assumes a 250 MHz system clock.
*/
package cal_pkg;
    localparam int CLK_HZ = 250_000_000;
    localparam int BLINK_HZ = 1;
    localparam int BLINK_HALF_CYC = CLK_HZ / (2 * BLINK_HZ);
    localparam int NV_WRITE_MS = 50;
    localparam int NV_WRITE_BUDGET = 100000;
    // Register byte offsets
    localparam logic [11:0] ADDR_CMP_CFG = 12'h000;
    localparam logic [11:0] ADDR_MEM_CFG = 12'h004;
    localparam logic [11:0] ADDR_RST_CFG = 12'h008;
    localparam logic [11:0] ADDR_STATUS = 12'h00c;
    localparam logic [31:0] CMP_CFG_RST = 32'h0000_2000;
    localparam logic [31:0] MEM_CFG_RST = 32'h0000_0000;
    localparam logic [31:0] RST_CFG_RST = 32'h0000_0000;
    // Field positions
    localparam int CMP_REL_LSB = 8;
    localparam int CMP_SIG_BIT = 11;
    localparam int CMP_CNT_LSB = 12;
    localparam int MEM_DPRE_BIT = 0;
    localparam int MEM_DCLR_BIT = 1;
    localparam int MEM_TCLR_BIT = 2;
    localparam int MEM_STORE_LSB = 8;
    localparam int RST_MCLR_BIT = 0;
    localparam int RST_MREQ_BIT = 1;
    localparam int RST_MTY2_BIT = 2;
    localparam int RST_NCLR_BIT = 3;
    localparam int RST_NREQ_BIT = 4;
    localparam int RST_NTY2_BIT = 5;
    localparam logic [3:0] CNT_MIN = 4'h2;
    localparam logic [3:0] CNT_MAX = 4'h8;
    localparam int SR_N = 8;

    typedef enum logic [2:0] {
        CAL_REL_LT = 3'h0,
        CAL_REL_GE = 3'h1,
        CAL_REL_GT = 3'h2,
        CAL_REL_LE = 3'h3,
        CAL_REL_EQ = 3'h4,
        CAL_REL_NE = 3'h5
    } cal_rel_t;

    typedef enum logic [1:0] {
        CAL_MON_IDLE = 2'h0,
        CAL_MON_ARMED = 2'h1,
        CAL_MON_SET = 2'h2
    } cal_mon_t;

    // Unused relation codes give a low output
    function automatic logic cal_rel_eval(logic [2:0] r, logic [7:0] x,
                                          logic [7:0] y);
        case (r)
            CAL_REL_LT: return x < y;
            CAL_REL_GE: return x >= y;
            CAL_REL_GT: return x > y;
            CAL_REL_LE: return x <= y;
            CAL_REL_EQ: return x == y;
            CAL_REL_NE: return x != y;
            default: return 1'b0;
        endcase
    endfunction
endpackage

//--- core/cal_top.sv
/*
 Compare and latch operators: magnitude comparator, D/T/SR memories,
 manual and monitored restart latches, with APB configuration.
 Assumes field inputs are asynchronous and an external non-volatile
 store that returns the saved SR image on nv_image_in after power-up.
*/
// The register addresses and the APB slave port are this design's own decisions.
// Functional notes
// - Constant mode compares 2 to 8 input bits against constant 0..255.
// - First input is LSB, highest configured input is MSB.
// - Constant mode only with signal comparison off; output follows relation.
// - Six relations; output high while relation holds, low otherwise.
// - Signal mode compares 4-bit group A with 4-bit group B.
// - Signal mode output high while relation of A to B holds.
// - D memory: clear wins, preset sets, else holds while strobe low.
// - D memory loads data on strobe rising edge; preset, clear optional.
// - T memory inverts on toggle rising edge; optional clear resets it.
// - SR memory: set alone sets, reset dominates, neither holds.
// - Stored SR memories write each change and restore at power-up.
// - At most eight SR memories have storage enabled.
// - Manual latch low on clear or input low; restart rising edge sets.
// - Type 1 request high only if not cleared, input high, not restarted.
// - Type 2 request high when cleared or input low, blinks 1 Hz waiting.
// - Monitored latch sets only on a complete restart pulse.
// - Clear input and request output exist only when enabled.
`timescale 1ns/1ps
module cal_top #(
    parameter int SCAN_CYC = 250,
    parameter int BLINK_HALF_CYC = cal_pkg::BLINK_HALF_CYC,
    parameter logic [7:0] SR_STORE_DEFAULT = 8'h00
) (
    input wire logic clk, // System clock
    input wire logic resetn, // Synchronous reset
    input wire logic psel, // APB select
    input wire logic penable, // APB enable
    input wire logic pwrite, // APB direction
    input wire logic [11:0] paddr, // APB byte address
    input wire logic [31:0] pwdata, // APB write data
    input wire logic [3:0] pstrb, // APB byte strobes
    output logic [31:0] prdata, // APB read data
    output logic pready, // APB ready
    output logic pslverr, // APB error
    input wire logic [7:0] operand_bits, // Comparator bits, bit0 LSB
    input wire logic [3:0] group_a_bits, // Group A, bit0 LSB
    input wire logic [3:0] group_b_bits, // Group B, bit0 LSB
    input wire logic dff_data, // D data
    input wire logic capture_strobe, // D strobe
    input wire logic dff_preset, // D preset
    input wire logic dff_clear, // D clear
    input wire logic tff_toggle, // T toggle
    input wire logic tff_clear, // T clear
    input wire logic [7:0] sr_set, // SR set per memory
    input wire logic [7:0] sr_reset, // SR reset per memory
    input wire logic [7:0] nv_image_in, // Saved SR image
    input wire logic man_clear, // Manual latch clear
    input wire logic man_restart, // Manual latch restart
    input wire logic man_input, // Manual latch monitored input
    input wire logic mon_clear, // Monitored latch clear
    input wire logic mon_restart, // Monitored latch restart
    input wire logic mon_input, // Monitored latch monitored input
    output logic cmp_out, // Comparator result
    output logic dff_q, // D output
    output logic tff_q, // T output
    output logic [7:0] sr_q, // SR outputs
    output logic nv_wr_stb, // Store request pulse
    output logic [7:0] nv_image_out, // Image to store
    output logic man_q, // Manual latch output
    output logic man_req, // Manual restart request
    output logic mon_q, // Monitored latch output
    output logic mon_req // Monitored restart request
);
    localparam int SW = 52;
    logic [SW-1:0] raw, s1_r, s2_r;
    logic [31:0] scan_cnt_r, blink_cnt_r;
    logic blink_r, restore_pend_r;
    logic [31:0] cmp_cfg_r, mem_cfg_r, rst_cfg_r, prdata_r;
    logic pready_r, pslverr_r;
    logic prev_stb_r, prev_tog_r, prev_mrst_r, prev_nrst_r;
    logic cmp_out_r, dff_q_r, tff_q_r, nv_wr_stb_r;
    logic [7:0] sr_q_r, nv_image_r;
    logic man_q_r, man_req_r, mon_req_r, mon_q_r;
    cal_pkg::cal_mon_t mon_state_r, mon_nxt;

    // Field pins cross into the clock domain through two flops
    assign raw = {operand_bits, group_a_bits, group_b_bits, dff_data,
                  capture_strobe, dff_preset, dff_clear, tff_toggle,
                  tff_clear, sr_set, sr_reset, nv_image_in, man_clear,
                  man_restart, man_input, mon_clear, mon_restart,
                  mon_input};
    always_ff @(posedge clk) begin
        s1_r <= raw;
        s2_r <= s1_r;
    end

    wire [7:0] f_opnd = s2_r[51:44];
    wire [3:0] f_ga = s2_r[43:40];
    wire [3:0] f_gb = s2_r[39:36];
    wire f_dd = s2_r[35];
    wire f_stb = s2_r[34];
    wire f_dpre = s2_r[33];
    wire f_dclr = s2_r[32];
    wire f_tog = s2_r[31];
    wire f_tclr = s2_r[30];
    wire [7:0] f_set = s2_r[29:22];
    wire [7:0] f_rst = s2_r[21:14];
    wire [7:0] f_img = s2_r[13:6];
    wire f_mclr = s2_r[5];
    wire f_mrst = s2_r[4];
    wire f_min = s2_r[3];
    wire f_nclr = s2_r[2];
    wire f_nrst = s2_r[1];
    wire f_nin = s2_r[0];

    // Scan divider: every operator steps on this one-cycle enable
    wire scan_tick = (scan_cnt_r == 32'(SCAN_CYC - 1));
    wire blink_wrap = (blink_cnt_r == 32'(BLINK_HALF_CYC - 1));
    always_ff @(posedge clk) begin
        if (!resetn) begin
            scan_cnt_r <= 32'h0;
            blink_cnt_r <= 32'h0;
            blink_r <= 1'b0;
        end else begin
            scan_cnt_r <= scan_tick ? 32'h0 : scan_cnt_r + 32'h1;
            blink_cnt_r <= blink_wrap ? 32'h0 : blink_cnt_r + 32'h1;
            if (blink_wrap) begin
                blink_r <= ~blink_r;
            end
        end
    end

    // Comparator operand selection
    wire [2:0] rel = cmp_cfg_r[cal_pkg::CMP_REL_LSB +: 3];
    wire sig_mode = cmp_cfg_r[cal_pkg::CMP_SIG_BIT];
    wire [3:0] cnt_raw = cmp_cfg_r[cal_pkg::CMP_CNT_LSB +: 4];
    wire [3:0] cnt_eff = (cnt_raw < cal_pkg::CNT_MIN) ? cal_pkg::CNT_MIN :
                         (cnt_raw > cal_pkg::CNT_MAX) ? cal_pkg::CNT_MAX :
                         cnt_raw;
    logic [7:0] opnd_m;
    for (genvar i = 0; i < 8; i++) begin : g_opnd
        // Bits beyond the configured count read as zero
        assign opnd_m[i] = f_opnd[i] & (4'(i) < cnt_eff);
    end
    wire [7:0] cmp_lhs = sig_mode ? {4'h0, f_ga} : opnd_m;
    wire [7:0] cmp_rhs = sig_mode ? {4'h0, f_gb} : cmp_cfg_r[7:0];
    wire cmp_val = cal_pkg::cal_rel_eval(rel, cmp_lhs, cmp_rhs);

    // D and T memories; clear and preset only count when enabled
    wire dpre = f_dpre & mem_cfg_r[cal_pkg::MEM_DPRE_BIT];
    wire dclr = f_dclr & mem_cfg_r[cal_pkg::MEM_DCLR_BIT];
    wire tclr = f_tclr & mem_cfg_r[cal_pkg::MEM_TCLR_BIT];
    wire stb_rise = f_stb & ~prev_stb_r;
    wire tog_rise = f_tog & ~prev_tog_r;
    wire dff_nxt = dclr ? 1'b0 : dpre ? 1'b1 :
                   stb_rise ? f_dd : dff_q_r;
    wire tff_nxt = tclr ? 1'b0 : tog_rise ? ~tff_q_r : tff_q_r;

    // SR memories; store mask is 8 bits so no more than eight persist
    wire [7:0] store_mask = mem_cfg_r[cal_pkg::MEM_STORE_LSB +: 8];
    logic [7:0] sr_nxt;
    for (genvar i = 0; i < cal_pkg::SR_N; i++) begin : g_sr
        // Reset dominates set, neither holds
        assign sr_nxt[i] = f_rst[i] ? 1'b0 : f_set[i] ? 1'b1 : sr_q_r[i];
    end
    wire nv_chg = |((sr_nxt ^ sr_q_r) & store_mask);

    // Manual restart latch
    wire mclr = f_mclr & rst_cfg_r[cal_pkg::RST_MCLR_BIT];
    wire m_block = mclr | ~f_min;
    wire mrst_rise = f_mrst & ~prev_mrst_r;
    wire man_nxt = m_block ? 1'b0 : mrst_rise ? 1'b1 : man_q_r;
    wire man_t1 = ~m_block & ~man_nxt;
    wire man_t2 = m_block | (~man_nxt & blink_r);
    wire man_req_nxt = rst_cfg_r[cal_pkg::RST_MREQ_BIT] &
                       (rst_cfg_r[cal_pkg::RST_MTY2_BIT] ? man_t2 : man_t1);

    // Monitored latch: rise arms, the following fall completes the pulse
    wire nclr = f_nclr & rst_cfg_r[cal_pkg::RST_NCLR_BIT];
    wire n_block = nclr | ~f_nin;
    wire nrst_rise = f_nrst & ~prev_nrst_r;
    wire nrst_fall = ~f_nrst & prev_nrst_r;
    always_comb begin
        mon_nxt = mon_state_r;
        if (n_block) begin
            mon_nxt = cal_pkg::CAL_MON_IDLE;
        end else begin
            unique case (mon_state_r)
                cal_pkg::CAL_MON_IDLE: begin
                    if (nrst_rise) begin
                        mon_nxt = cal_pkg::CAL_MON_ARMED;
                    end
                end
                cal_pkg::CAL_MON_ARMED: begin
                    if (nrst_fall) begin
                        mon_nxt = cal_pkg::CAL_MON_SET;
                    end
                end
                cal_pkg::CAL_MON_SET: mon_nxt = cal_pkg::CAL_MON_SET;
                default: mon_nxt = cal_pkg::CAL_MON_IDLE;
            endcase
        end
    end
    wire mon_set_nxt = (mon_nxt == cal_pkg::CAL_MON_SET);
    wire mon_t1 = ~n_block & ~mon_set_nxt;
    wire mon_t2 = n_block | (~mon_set_nxt & blink_r);
    wire mon_req_nxt = rst_cfg_r[cal_pkg::RST_NREQ_BIT] &
                       (rst_cfg_r[cal_pkg::RST_NTY2_BIT] ? mon_t2 : mon_t1);

    // Operator state steps only on the scan enable
    always_ff @(posedge clk) begin
        if (!resetn) begin
            {prev_stb_r, prev_tog_r, prev_mrst_r, prev_nrst_r} <= 4'h0;
            {cmp_out_r, dff_q_r, tff_q_r, man_q_r} <= 4'h0;
            {man_req_r, mon_req_r, mon_q_r} <= 3'h0;
            mon_state_r <= cal_pkg::CAL_MON_IDLE;
        end else if (scan_tick) begin
            prev_stb_r <= f_stb;
            prev_tog_r <= f_tog;
            prev_mrst_r <= f_mrst;
            prev_nrst_r <= f_nrst;
            cmp_out_r <= cmp_val;
            dff_q_r <= dff_nxt;
            tff_q_r <= tff_nxt;
            man_q_r <= man_nxt;
            man_req_r <= man_req_nxt;
            mon_state_r <= mon_nxt;
            mon_req_r <= mon_req_nxt;
            mon_q_r <= mon_set_nxt;
        end
    end

    // First scan after reset restores the saved image instead of stepping;
    // the divider guarantees the synchroniser has filled by then
    always_ff @(posedge clk) begin
        if (!resetn) begin
            restore_pend_r <= 1'b1;
            sr_q_r <= 8'h00;
            nv_wr_stb_r <= 1'b0;
            nv_image_r <= 8'h00;
        end else begin
            nv_wr_stb_r <= 1'b0;
            if (scan_tick && restore_pend_r) begin
                restore_pend_r <= 1'b0;
                sr_q_r <= f_img & SR_STORE_DEFAULT;
            end else if (scan_tick) begin
                sr_q_r <= sr_nxt;
                nv_wr_stb_r <= nv_chg;
                nv_image_r <= sr_nxt & store_mask;
            end
        end
    end

    // APB slave, one wait state so read data leaves a flop
    wire acc = psel & penable;
    wire fire = acc & pready_r;
    wire a_cmp = (paddr == cal_pkg::ADDR_CMP_CFG);
    wire a_mem = (paddr == cal_pkg::ADDR_MEM_CFG);
    wire a_rst = (paddr == cal_pkg::ADDR_RST_CFG);
    wire a_sts = (paddr == cal_pkg::ADDR_STATUS);
    wire a_hit = a_cmp | a_mem | a_rst | a_sts;
    logic [31:0] wmask;
    for (genvar b = 0; b < 4; b++) begin : g_strb
        assign wmask[8*b +: 8] = {8{pstrb[b]}};
    end
    wire [31:0] sts = {12'h0, mon_req_r, man_req_r,
                       mon_state_r == cal_pkg::CAL_MON_SET, man_q_r,
                       sr_q_r, 5'h0, tff_q_r, dff_q_r, cmp_out_r};
    wire [31:0] rd_mux = a_cmp ? cmp_cfg_r : a_mem ? mem_cfg_r :
                         a_rst ? rst_cfg_r : a_sts ? sts : 32'h0;
    wire wr = fire & pwrite & ~a_sts;
    always_ff @(posedge clk) begin
        if (!resetn) begin
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
            prdata_r <= 32'h0;
            cmp_cfg_r <= cal_pkg::CMP_CFG_RST;
            mem_cfg_r <= cal_pkg::MEM_CFG_RST | {16'h0, SR_STORE_DEFAULT, 8'h0};
            rst_cfg_r <= cal_pkg::RST_CFG_RST;
        end else begin
            pready_r <= acc & ~pready_r;
            pslverr_r <= acc & ~pready_r & ~a_hit;
            prdata_r <= (acc & ~pwrite & ~pready_r) ? rd_mux : 32'h0;
            if (wr && a_cmp) begin
                cmp_cfg_r <= (cmp_cfg_r & ~wmask) | (pwdata & wmask);
            end
            if (wr && a_mem) begin
                mem_cfg_r <= (mem_cfg_r & ~wmask) | (pwdata & wmask);
            end
            if (wr && a_rst) begin
                rst_cfg_r <= (rst_cfg_r & ~wmask) | (pwdata & wmask);
            end
        end
    end

    assign prdata = prdata_r;
    assign pready = pready_r;
    assign pslverr = pslverr_r;
    assign cmp_out = cmp_out_r;
    assign dff_q = dff_q_r;
    assign tff_q = tff_q_r;
    assign sr_q = sr_q_r;
    assign nv_wr_stb = nv_wr_stb_r;
    assign nv_image_out = nv_image_r;
    assign man_q = man_q_r;
    assign man_req = man_req_r;
    assign mon_q = mon_q_r;
    assign mon_req = mon_req_r;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);

    a_cmp_eq_const: assert property (scan_tick && !sig_mode &&
        rel == cal_pkg::CAL_REL_EQ && opnd_m == cmp_cfg_r[7:0] |=> cmp_out_r)
        else $error("equal constant not flagged");
    a_cmp_msb_mask: assert property (!sig_mode && cnt_eff == 4'h2 |->
        cmp_lhs[7:2] == 6'h0)
        else $error("bits above count leak into operand");
    a_cmp_hold: assert property (!scan_tick |=> $stable(cmp_out_r))
        else $error("comparator changed between scans");
    a_cmp_grp_lt: assert property (scan_tick && sig_mode &&
        rel == cal_pkg::CAL_REL_LT |=>
        cmp_out_r == ($past(f_ga) < $past(f_gb)))
        else $error("group compare wrong");
    a_dff_clear: assert property (scan_tick && dclr |=> !dff_q_r)
        else $error("clear did not win");
    a_dff_load: assert property (scan_tick && !dclr && !dpre &&
        stb_rise |=> dff_q_r == $past(f_dd))
        else $error("data not loaded on strobe");
    a_tff_flip: assert property (scan_tick && !tclr && tog_rise |=>
        tff_q_r != $past(tff_q_r))
        else $error("toggle missed");
    a_sr_dominant: assert property (scan_tick && !restore_pend_r &&
        f_rst[0] |=> !sr_q_r[0])
        else $error("reset did not dominate");
    a_nv_write: assert property (scan_tick && !restore_pend_r &&
        nv_chg |=> nv_wr_stb_r ##1 !nv_wr_stb_r)
        else $error("store pulse wrong");
    a_man_block: assert property (scan_tick && m_block |=>
        !man_q_r && (!man_req_r || $past(rst_cfg_r[cal_pkg::RST_MTY2_BIT])))
        else $error("manual latch not held low");
    a_mon_pulse: assert property (scan_tick &&
        mon_state_r == cal_pkg::CAL_MON_IDLE |=> !mon_q)
        else $error("monitored latch set without pulse");
    a_req_gate: assert property (!rst_cfg_r[cal_pkg::RST_MREQ_BIT] &&
        scan_tick |=> !man_req_r)
        else $error("request output not gated");
    a_apb_wait: assert property (acc && !pready_r |=> pready_r ##1 !pready_r)
        else $error("apb ready timing");
    c_mon_set: cover property (mon_state_r == cal_pkg::CAL_MON_ARMED ##1
        mon_state_r == cal_pkg::CAL_MON_SET);
    c_nv_store: cover property (nv_wr_stb_r);
    c_blink_req: cover property (man_req_r ##1 !man_req_r);
endmodule

//--- dv/cal_nv_model.sv
/*
 Far-side model: the non-volatile store that keeps the SR image.
 Assumes one nv_wr_stb pulse per stored change; it keeps its image
 across resets of the design, as the real store keeps it off power.
*/
`timescale 1ns/1ps
module cal_nv_model #(
    parameter logic [7:0] POWER_IMAGE = 8'h00
) (
    input wire logic clk, // System clock
    input wire logic nv_wr_stb, // Store request pulse
    input wire logic [7:0] nv_image_out, // Image to save
    output logic [7:0] nv_image_in, // Saved image
    output int n_writes // Stores taken so far
);
    logic [7:0] image_r = POWER_IMAGE;
    int count_r = 0;
    // No reset here on purpose: a design reset must not wipe the store
    always_ff @(posedge clk) begin
        if (nv_wr_stb) begin
            image_r <= nv_image_out;
            count_r <= count_r + 1;
        end
    end
    assign nv_image_in = image_r;
    assign n_writes = count_r;
endmodule

//--- dv/testbench.sv
/*
 Self-checking bench for the compare and latch operators.
 Assumes short scan and blink periods set through the parameters,
 and a store model that survives resets of the design.
*/
`timescale 1ns/1ps
module testbench;
    localparam int SCAN = 4;
    localparam int SETTLE = 3 * SCAN + 4;
    localparam logic [7:0] SR_DEF = 8'hff;
    localparam logic [7:0] PWR_IMG = 8'ha5;
    // D steps: preset, clear, strobe, data, expected q
    localparam logic [4:0] DSEQ [8] = '{5'h11, 5'h0a, 5'h18, 5'h02,
        5'h07, 5'h05, 5'h01, 5'h04};
    // Latch steps: clr, restart, in, man q, man req, mon q, mon req code
    localparam logic [7:0] LSEQ [9] = '{8'h01, 8'h2a, 8'h73, 8'h34,
        8'ha1, 8'h2a, 8'h01, 8'h73, 8'h34};
    logic clk = 1'b0, resetn = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata;
    logic [7:0] operand_bits = 8'h00, sr_set = 8'h00, sr_reset = 8'h00;
    logic [3:0] group_a_bits = 4'h0, group_b_bits = 4'h0;
    logic dff_data = 1'b0, capture_strobe = 1'b0, dff_preset = 1'b0;
    logic dff_clear = 1'b0, tff_toggle = 1'b0, tff_clear = 1'b0;
    logic man_clear = 1'b0, man_restart = 1'b0, man_input = 1'b0;
    logic mon_clear = 1'b0, mon_restart = 1'b0, mon_input = 1'b0;
    logic pready, pslverr, cmp_out, dff_q, tff_q, nv_wr_stb;
    logic man_q, man_req, mon_q, mon_req;
    logic [7:0] sr_q, nv_image_out, nv_image_in;
    int n_writes, errors = 0, n_compared = 0, cyc = 0;
    int seed = 32'h541d;

    // 250 MHz clock
    always #2 clk = ~clk;

    // Short scan and blink keep the run brief
    cal_top #(.SCAN_CYC(SCAN), .BLINK_HALF_CYC(8),
        .SR_STORE_DEFAULT(SR_DEF)) uut (.clk, .resetn, .psel, .penable,
        .pwrite, .paddr, .pwdata, .pstrb(4'hf), .prdata, .pready,
        .pslverr, .operand_bits, .group_a_bits, .group_b_bits, .dff_data,
        .capture_strobe, .dff_preset, .dff_clear, .tff_toggle, .tff_clear,
        .sr_set, .sr_reset, .nv_image_in, .man_clear, .man_restart,
        .man_input, .mon_clear, .mon_restart, .mon_input, .cmp_out, .dff_q,
        .tff_q, .sr_q, .nv_wr_stb, .nv_image_out, .man_q, .man_req, .mon_q,
        .mon_req);
    cal_nv_model #(.POWER_IMAGE(PWR_IMG)) store (.clk, .nv_wr_stb,
        .nv_image_out, .nv_image_in, .n_writes);

    task automatic test_done;
        if (errors == 0 && n_compared > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // Cycle ceiling cuts a hang short, a bus wait included
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 10000) begin
            errors = errors + 1;
            test_done();
        end
    end

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_compared = n_compared + 1;
        if (got !== exp) begin
            errors = errors + 1;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // One APB transfer; on a read, d is the expected data
    task automatic bus(input logic w, input logic [11:0] a,
                       input logic [31:0] d, input logic eer);
        logic [31:0] rd;
        logic er;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (!w) begin
            check(rd, d);
            check(32'(er), 32'(eer));
        end
    endtask

    // Long enough for three scans plus the input synchronisers
    task automatic settle;
        repeat (SETTLE) @(posedge clk);
    endtask

    function automatic logic rel_exp(input logic [2:0] r,
                                     input logic [7:0] x, y);
        case (r)
            3'h0: return x < y;
            3'h1: return x >= y;
            3'h2: return x > y;
            3'h3: return x <= y;
            3'h4: return x == y;
            3'h5: return x != y;
            default: return 1'b0;
        endcase
    endfunction

    // Main sequence
    initial begin
        logic [7:0] k, x, m, y, exp_sr;
        logic [3:0] cnt, a, b;
        logic [2:0] rel;
        logic sig, seen0, seen1, tq;
        repeat (16) @(posedge clk);
        resetn <= 1'b1;
        settle();
        check(32'(sr_q), 32'(PWR_IMG & SR_DEF));
        bus(1'b0, cal_pkg::ADDR_CMP_CFG, cal_pkg::CMP_CFG_RST, 1'b0);
        bus(1'b0, cal_pkg::ADDR_MEM_CFG, {16'h0, SR_DEF, 8'h00}, 1'b0);
        bus(1'b0, cal_pkg::ADDR_RST_CFG, cal_pkg::RST_CFG_RST, 1'b0);
        bus(1'b0, 12'h010, 32'h0, 1'b1);
        bus(1'b1, cal_pkg::ADDR_STATUS, 32'hffff_ffff, 1'b0);
        bus(1'b0, cal_pkg::ADDR_STATUS, {16'h0, PWR_IMG, 8'h00}, 1'b0);
        // Comparator: constant mode first half, signal mode second half
        for (int i = 0; i < 32; i++) begin
            cnt = 4'(2 + $unsigned($random(seed)) % 7);
            rel = 3'(i % 8);
            sig = i >= 16;
            x = 8'($random(seed));
            k = 8'($random(seed));
            if (i < 2) begin
                cnt = i ? 4'h5 : 4'h8;
                x = i ? 8'hfa : 8'h96;
                k = i ? 8'h1a : 8'h96;
                rel = 3'h4;
            end
            a = x[3:0];
            b = k[3:0];
            m = 8'((16'h1 << cnt) - 16'h1);
            y = sig ? {4'h0, b} : k;
            bus(1'b1, cal_pkg::ADDR_CMP_CFG, {16'h0, cnt, sig, rel, k}, 1'b0);
            operand_bits <= x;
            group_a_bits <= a;
            group_b_bits <= b;
            settle();
            m = sig ? {4'h0, a} : x & m;
            check(32'(cmp_out), 32'(rel_exp(rel, m, y)));
        end
        // D memory with preset, clear and T clear enabled
        bus(1'b1, cal_pkg::ADDR_MEM_CFG, {16'h0, SR_DEF, 8'h07}, 1'b0);
        for (int i = 0; i < 8; i++) begin
            {dff_preset, dff_clear, capture_strobe, dff_data} <= DSEQ[i][4:1];
            settle();
            check(32'(dff_q), 32'(DSEQ[i][0]));
        end
        bus(1'b1, cal_pkg::ADDR_MEM_CFG, {16'h0, SR_DEF, 8'h04}, 1'b0);
        dff_preset <= 1'b1;
        settle();
        check(32'(dff_q), 32'h0);
        tq = 1'b0;
        for (int i = 0; i < 6; i++) begin
            tff_toggle <= !i[0];
            tq = tq ^ !i[0];
            settle();
            check(32'(tff_q), 32'(tq));
        end
        tff_clear <= 1'b1;
        settle();
        check(32'(tff_q), 32'h0);
        // SR memories, every one stored; steps kept far apart
        exp_sr = PWR_IMG & SR_DEF;
        for (int i = 0; i < 12; i++) begin
            x = 8'($random(seed));
            m = 8'($random(seed)) & 8'($random(seed));
            sr_set <= x;
            sr_reset <= m;
            exp_sr = (exp_sr | x) & ~m;
            settle();
            check(32'(sr_q), 32'(exp_sr));
            check(32'(nv_image_in), 32'(exp_sr & SR_DEF));
        end
        // Release set and reset so the restore below is seen on its own
        sr_set <= 8'h00;
        sr_reset <= 8'h00;
        check(32'(n_writes <= cal_pkg::NV_WRITE_BUDGET), 32'h1);
        // Manual latch type 1, monitored latch type 2, clears enabled
        bus(1'b1, cal_pkg::ADDR_RST_CFG, 32'h0000_003b, 1'b0);
        for (int i = 0; i < 9; i++) begin
            {man_clear, man_restart, man_input} <= LSEQ[i][7:5];
            {mon_clear, mon_restart, mon_input} <= LSEQ[i][7:5];
            settle();
            check(32'({man_q, man_req}), 32'(LSEQ[i][4:3]));
            check(32'(mon_q), 32'(LSEQ[i][2]));
            seen0 = 1'b0;
            seen1 = 1'b0;
            repeat (40) begin
                @(posedge clk);
                seen0 = seen0 | (mon_req === 1'b0);
                seen1 = seen1 | (mon_req === 1'b1);
            end
            if (LSEQ[i][1:0] !== 2'h3) begin
                check(32'({seen1, seen0}), 32'(LSEQ[i][1:0]) + 32'h1);
            end
        end
        // Options off: clear ignored, requests held low
        bus(1'b1, cal_pkg::ADDR_RST_CFG, 32'h0, 1'b0);
        man_clear <= 1'b1;
        mon_clear <= 1'b1;
        settle();
        check(32'({man_q, man_req, mon_q, mon_req}), 32'ha);
        // Second power-up restores the last stored image
        resetn <= 1'b0;
        repeat (3) @(posedge clk);
        resetn <= 1'b1;
        settle();
        check(32'(sr_q), 32'(exp_sr & SR_DEF));
        test_done();
    end
endmodule
